// [logic/quad_io_pkg.sv]
// shared constants for the quad i/o port with external interrupt sources
// Function
// RULE1: data bits drive pins, high bits direction
// RULE2: pin zero open drain, others push-pull
// RULE3: pull-up follows each pin data bit
// RULE4: read returns live pins, stored direction
// RULE5: sources zero/one detect levels or edges
// RULE6: polarity and level bits select condition
// RULE7: sources two/three detect fall, rise, both
// RULE8: software clears flags; hardware never does
// RULE9: count pulse from selected pin two/three
// RULE10: low capture from pin zero or two
// RULE11: level-mode pin zero captures every cycle
// RULE12: high capture from pin one or three
// RULE13: level-mode pin one captures every cycle
// RULE14: flag with enable releases deep stop; source three never releases it here
// RULE15: level on pins zero/one wakes stop
// RULE16: pins zero/one wake only in level mode
// RULE17: pin two edge in stop sets, wakes
// RULE18: pin two ignores edge matching entry level
// RULE19: software should use both edges there
// RULE20: request while flag and enable both set
// RULE21: edges from sample versus previous sample
package quad_io_pkg;
    localparam int ADDR_W = 18;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_PORT_CTRL = 16'hFE5C;
    localparam logic [15:0] IDX_LVL_CTRL = 16'hFE5D;
    localparam logic [15:0] IDX_EDGE_CTRL = 16'hFE5E;
    localparam logic [15:0] IDX_INPUT_SEL = 16'hFE5F;
    localparam logic [15:0] IDX_DATA_VIEW = 16'hFE60;
    localparam logic [7:0] RST_PORT_CTRL = 8'h00;
    localparam logic [7:0] RST_LVL_CTRL = 8'h00;
    localparam logic [7:0] RST_EDGE_CTRL = 8'h00;
    localparam logic [7:0] RST_INPUT_SEL = 8'h00;
    localparam int DIR_LSB = 4;
    // level control: source n fields at base 4*n
    localparam int SRC_EN = 0;
    localparam int SRC_FLAG = 1;
    localparam int SRC_LVL = 2;
    localparam int SRC_POL = 3;
    // edge control: source 2+n fields at base 4*n
    localparam int SRC_FALL = 2;
    localparam int SRC_RISE = 3;
    localparam int SRC_STRIDE = 4;
    localparam int ISL_CNT_SEL = 0;
    localparam int ISL_LOW_CAP_SEL = 6;
    localparam int ISL_HIGH_CAP_SEL = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/pin_sync.sv]
// three-stage pin synchroniser with agreed level and edge pulses
`timescale 1ns/1ps
module pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_pin,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
        logic rise;
        logic fall;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.s1 = i_pin;
        next_state.s2 = state.s1;
        next_state.s3 = state.s2;
        next_state.rise = 1'b0;
        next_state.fall = 1'b0;
        // RULE21 compare with previous
        if (state.s2 == state.s3) begin
            next_state.level = state.s3;
            next_state.rise = state.s3 & ~state.level;
            next_state.fall = ~state.s3 & state.level;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_level = state.level;
    assign o_rise = state.rise;
    assign o_fall = state.fall;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    edge_single_a: assert property (o_rise |=> !o_rise) // RULE21
        else $error("rise pulse longer than one cycle");
endmodule // pin_sync

// [logic/quad_io_port.sv]
// quad i/o port with external interrupt detection and axi4-lite registers
`timescale 1ns/1ps
module quad_io_port (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [quad_io_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [quad_io_pkg::ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [3:0] i_pin,
    output logic [3:0] o_pin,
    output logic [3:0] o_pin_oe_n,
    output logic [3:0] o_pullup_en,
    input wire logic i_deep_stop,
    output logic [3:0] o_irq_req,
    output logic o_stop_release,
    output logic o_count_pulse,
    output logic o_cap_low,
    output logic o_cap_high
);
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } rd_state_t;

    typedef struct packed {
        wr_state_t wr;
        rd_state_t rd;
        logic aw_got;
        logic w_got;
        logic [15:0] aw_idx;
        logic [7:0] wbyte;
        logic wen;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] port_ctrl;
        logic [7:0] lvl_ctrl;
        logic [7:0] edge_ctrl;
        logic [7:0] input_sel;
        logic stop_q;
        logic entry_level;
        logic count_pulse;
        logic cap_low;
        logic cap_high;
    } port_state_t;

    port_state_t state;
    port_state_t next_state;

    localparam int SRC_STRIDE = quad_io_pkg::SRC_STRIDE;
    localparam int DIR_LSB = quad_io_pkg::DIR_LSB;

    logic [3:0] pin_level;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;
    logic [3:0] event_hit;
    logic [3:0] flag;
    logic [3:0] enable;
    logic in_stop;
    logic wr_apply;
    logic aw_take;
    logic w_take;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            pin_sync u_sync (
                .i_clk(i_clk),
                .i_rst_n(i_rst_n),
                .i_pin(i_pin[g]),
                .o_level(pin_level[g]),
                .o_rise(pin_rise[g]),
                .o_fall(pin_fall[g])
            );
        end
    endgenerate

    // stop state counts only after the entry level is latched
    assign in_stop = i_deep_stop & state.stop_q;
    assign wr_apply = (state.wr == WR_IDLE) & state.aw_got & state.w_got;
    assign aw_take = i_awvalid & o_awready;
    assign w_take = i_wvalid & o_wready;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            flag[i] = state.lvl_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_FLAG];
            enable[i] = state.lvl_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_EN];
            flag[i+2] = state.edge_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_FLAG];
            enable[i+2] = state.edge_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_EN];
        end
    end

    // detection conditions per source
    always_comb begin
        logic lvl_mode;
        logic pol;
        logic rise_en;
        logic fall_en;
        lvl_mode = 1'b0;
        pol = 1'b0;
        rise_en = 1'b0;
        fall_en = 1'b0;
        event_hit = 4'h0;
        for (int i = 0; i < 2; i++) begin
            lvl_mode = state.lvl_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_LVL];
            pol = state.lvl_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_POL];
            // RULE5 RULE6 level or edge
            if (lvl_mode) begin
                event_hit[i] = (pin_level[i] == pol);
            end else if (!in_stop) begin
                // RULE16 edges idle in stop
                event_hit[i] = pol ? pin_rise[i] : pin_fall[i];
            end
        end
        for (int i = 0; i < 2; i++) begin
            rise_en = state.edge_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_RISE];
            fall_en = state.edge_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_FALL];
            // RULE7 fall rise both
            event_hit[i+2] = (pin_rise[i+2] & rise_en) | (pin_fall[i+2] & fall_en);
        end
        // RULE17 RULE18 entry level gating
        if (in_stop) begin
            event_hit[2] = (pin_rise[2] & state.edge_ctrl[quad_io_pkg::SRC_RISE]
                & ~state.entry_level)
                | (pin_fall[2] & state.edge_ctrl[quad_io_pkg::SRC_FALL]
                & state.entry_level);
        end
    end

    always_comb begin
        next_state = state;
        // write channel: address and data in either order
        case (state.wr)
            WR_IDLE: begin
                if (aw_take) begin
                    next_state.aw_got = 1'b1;
                    next_state.aw_idx = i_awaddr[17:2];
                end
                if (w_take) begin
                    next_state.w_got = 1'b1;
                    next_state.wbyte = i_wdata[7:0];
                    next_state.wen = i_wstrb[0];
                end
                if (wr_apply) begin
                    next_state.wr = WR_RESP;
                    next_state.bresp = quad_io_pkg::RESP_OKAY;
                    case (state.aw_idx)
                        quad_io_pkg::IDX_PORT_CTRL,
                        quad_io_pkg::IDX_DATA_VIEW: begin
                            if (state.wen) next_state.port_ctrl = state.wbyte;
                        end
                        quad_io_pkg::IDX_LVL_CTRL: begin
                            if (state.wen) next_state.lvl_ctrl = state.wbyte;
                        end
                        quad_io_pkg::IDX_EDGE_CTRL: begin
                            if (state.wen) next_state.edge_ctrl = state.wbyte;
                        end
                        quad_io_pkg::IDX_INPUT_SEL: begin
                            if (state.wen) next_state.input_sel = state.wbyte;
                        end
                        default: begin
                            next_state.bresp = quad_io_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            WR_RESP: begin
                if (i_bready) begin
                    next_state.wr = WR_IDLE;
                    next_state.aw_got = 1'b0;
                    next_state.w_got = 1'b0;
                end
            end
            default: begin
                next_state.wr = WR_IDLE;
                next_state.aw_got = 1'b0;
                next_state.w_got = 1'b0;
            end
        endcase

        // read channel
        case (state.rd)
            RD_IDLE: begin
                if (i_arvalid) begin
                    next_state.rd = RD_DATA;
                    next_state.rresp = quad_io_pkg::RESP_OKAY;
                    next_state.rdata = 32'h0000_0000;
                    case (i_araddr[17:2])
                        // RULE4 live pins, stored direction
                        quad_io_pkg::IDX_PORT_CTRL: begin
                            next_state.rdata[7:0] = {state.port_ctrl[7:4], pin_level};
                        end
                        // stored latch for read-modify-write sequences
                        quad_io_pkg::IDX_DATA_VIEW: begin
                            next_state.rdata[7:0] = state.port_ctrl;
                        end
                        quad_io_pkg::IDX_LVL_CTRL: next_state.rdata[7:0] = state.lvl_ctrl;
                        quad_io_pkg::IDX_EDGE_CTRL: next_state.rdata[7:0] = state.edge_ctrl;
                        quad_io_pkg::IDX_INPUT_SEL: next_state.rdata[7:0] = state.input_sel;
                        default: next_state.rresp = quad_io_pkg::RESP_SLVERR;
                    endcase
                end
            end
            RD_DATA: begin
                if (i_rready) next_state.rd = RD_IDLE;
            end
            default: next_state.rd = RD_IDLE;
        endcase

        // RULE8 set wins over clear
        for (int i = 0; i < 2; i++) begin
            if (event_hit[i]) next_state.lvl_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_FLAG] = 1'b1;
            if (event_hit[i+2]) begin
                next_state.edge_ctrl[SRC_STRIDE*i+quad_io_pkg::SRC_FLAG] = 1'b1;
            end
        end

        next_state.stop_q = i_deep_stop;
        if (i_deep_stop && !state.stop_q) next_state.entry_level = pin_level[2];

        // RULE9 count source select
        next_state.count_pulse = state.input_sel[quad_io_pkg::ISL_CNT_SEL]
            ? event_hit[3] : event_hit[2];
        // RULE10 RULE11 low capture
        next_state.cap_low = state.input_sel[quad_io_pkg::ISL_LOW_CAP_SEL]
            ? event_hit[0] : event_hit[2];
        // RULE12 RULE13 high capture
        next_state.cap_high = state.input_sel[quad_io_pkg::ISL_HIGH_CAP_SEL]
            ? event_hit[1] : event_hit[3];
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= '0;
            state.wr <= WR_IDLE;
            state.rd <= RD_IDLE;
            state.port_ctrl <= quad_io_pkg::RST_PORT_CTRL;
            state.lvl_ctrl <= quad_io_pkg::RST_LVL_CTRL;
            state.edge_ctrl <= quad_io_pkg::RST_EDGE_CTRL;
            state.input_sel <= quad_io_pkg::RST_INPUT_SEL;
        end else begin
            state <= next_state;
        end
    end

    assign o_awready = (state.wr == WR_IDLE) & ~state.aw_got;
    assign o_wready = (state.wr == WR_IDLE) & ~state.w_got;
    assign o_bvalid = (state.wr == WR_RESP);
    assign o_bresp = state.bresp;
    assign o_arready = (state.rd == RD_IDLE);
    assign o_rvalid = (state.rd == RD_DATA);
    assign o_rdata = state.rdata;
    assign o_rresp = state.rresp;

    // RULE1 RULE2 pin drivers
    assign o_pin = {state.port_ctrl[3:1], 1'b0};
    // pin zero only sinks: released whenever its data bit is one
    assign o_pin_oe_n = {~state.port_ctrl[7:5],
        ~(state.port_ctrl[DIR_LSB] & ~state.port_ctrl[0])};
    // RULE3 pull-up from data
    assign o_pullup_en = state.port_ctrl[3:0];

    // RULE20 request from flag and enable
    assign o_irq_req = flag & enable;
    // RULE14 RULE15 RULE16 stop release
    assign o_stop_release = (o_irq_req[0] & state.lvl_ctrl[quad_io_pkg::SRC_LVL])
        | (o_irq_req[1] & state.lvl_ctrl[SRC_STRIDE+quad_io_pkg::SRC_LVL])
        | o_irq_req[2];

    assign o_count_pulse = state.count_pulse;
    assign o_cap_low = state.cap_low;
    assign o_cap_high = state.cap_high;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    pin_drive_a: assert property (state.port_ctrl[5] |-> !o_pin_oe_n[1] // RULE1
        && o_pin[1] == state.port_ctrl[1])
        else $error("pin one not driven from its data bit");
    open_drain_a: assert property (state.port_ctrl[0] |-> o_pin_oe_n[0]) // RULE2
        else $error("open-drain pin driven while data is one");
    pullup_follow_a: assert property (o_pullup_en == state.port_ctrl[3:0]) // RULE3
        else $error("pull-up does not follow data bits");
    read_live_a: assert property (o_arready && i_arvalid // RULE4
        && i_araddr[17:2] == quad_io_pkg::IDX_PORT_CTRL
        |=> o_rvalid && o_rdata[3:0] == $past(pin_level))
        else $error("port read does not return live pin levels");
    level_flag_a: assert property (state.lvl_ctrl[quad_io_pkg::SRC_LVL] // RULE6
        && pin_level[0] == state.lvl_ctrl[quad_io_pkg::SRC_POL]
        |=> flag[0])
        else $error("level condition did not set source zero flag");
    edge_flag_a: assert property (!in_stop && pin_rise[3] // RULE7
        && state.edge_ctrl[SRC_STRIDE+quad_io_pkg::SRC_RISE] |=> flag[3])
        else $error("rising edge did not set source three flag");
    count_pulse_a: assert property (event_hit[3] // RULE9
        && state.input_sel[quad_io_pkg::ISL_CNT_SEL] |=> o_count_pulse)
        else $error("count pulse missing for selected source");
    cap_level_a: assert property ((state.input_sel[quad_io_pkg::ISL_LOW_CAP_SEL] // RULE11
        && state.lvl_ctrl[quad_io_pkg::SRC_LVL]
        && pin_level[0] == state.lvl_ctrl[quad_io_pkg::SRC_POL])[*3]
        |=> o_cap_low && $past(o_cap_low))
        else $error("level capture not repeated every cycle");
    flag_sticky_a: assert property (flag[2] && !wr_apply |=> flag[2]) // RULE8
        else $error("source two flag cleared without a write");
    stop_edge_a: assert property (in_stop && !state.lvl_ctrl[quad_io_pkg::SRC_LVL] // RULE16
        && !flag[0] && !wr_apply |=> !flag[0])
        else $error("edge on pin zero set flag during stop");
    stop_ignore_a: assert property (in_stop && state.entry_level && pin_rise[2] // RULE18
        && !flag[2] && !wr_apply |=> !flag[2])
        else $error("rise ignored at high entry level set flag");
    release_a: assert property (flag[2] && enable[2] |-> o_stop_release) // RULE14
        else $error("stop release missing for source two");

    wake_cover_c: cover property (in_stop ##1 o_stop_release);
    write_cover_c: cover property (o_bvalid && i_bready && o_bresp == quad_io_pkg::RESP_OKAY);
    capture_cover_c: cover property (o_cap_low ##1 o_cap_low ##1 o_cap_low);
endmodule // quad_io_port

// [tb/ext_pin_model.sv]
// off-chip circuits on the four port pins: drivers, pull-ups, floating lines
`timescale 1ns/1ps
module ext_pin_model (
    input wire logic i_clk,
    input wire logic [3:0] i_pin_out,
    input wire logic [3:0] i_pin_oe_n,
    input wire logic [3:0] i_pullup_en,
    input wire logic [3:0] i_drive_val,
    input wire logic [3:0] i_drive_en,
    output logic [3:0] o_level
);
    logic [3:0] last = 4'h0;
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            if (!i_pin_oe_n[b]) begin
                o_level[b] = i_pin_out[b];
            end else if (i_drive_en[b]) begin
                o_level[b] = i_drive_val[b];
            end else if (i_pullup_en[b]) begin
                o_level[b] = 1'b1;
            end else begin
                // undriven line wanders, so a stale level never reads as valid
                o_level[b] = ~last[b];
            end
        end
    end
    always @(posedge i_clk) begin
        last <= o_level;
    end
endmodule // ext_pin_model

// [tb/tb_quad_io_port.sv]
// self-checking bench for the quad i/o port over axi4-lite
`timescale 1ns/1ps
module tb_quad_io_port;
    localparam logic [15:0] P_PORT = quad_io_pkg::IDX_PORT_CTRL;
    localparam logic [15:0] P_LVL = quad_io_pkg::IDX_LVL_CTRL;
    localparam logic [15:0] P_EDGE = quad_io_pkg::IDX_EDGE_CTRL;
    localparam logic [15:0] P_ISL = quad_io_pkg::IDX_INPUT_SEL;
    localparam logic [15:0] P_VIEW = quad_io_pkg::IDX_DATA_VIEW;
    localparam logic [31:0] SLV = 32'(quad_io_pkg::RESP_SLVERR);
    logic i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_deep_stop;
    logic [17:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rdv;
    logic [3:0] i_wstrb, pin_level, o_pin, o_pin_oe_n, o_pullup_en, o_irq_req;
    logic [3:0] drive_val, drive_en, va, vi;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic o_stop_release, o_count_pulse, o_cap_low, o_cap_high;
    logic [1:0] o_bresp, o_rresp, rsp;
    logic [7:0] cfg, fl;
    int bad_count = 0, checks_done = 0, cycles = 0, n_cnt = 0, n_low = 0, n_high = 0;
    int n0, l0, h0, nev;

    quad_io_port u_quad_io_port (
        .i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_pin(pin_level), .o_pin,
        .o_pin_oe_n, .o_pullup_en, .i_deep_stop, .o_irq_req, .o_stop_release,
        .o_count_pulse, .o_cap_low, .o_cap_high
    );
    ext_pin_model u_ext_pin_model (
        .i_clk(i_clk), .i_pin_out(o_pin), .i_pin_oe_n(o_pin_oe_n),
        .i_pullup_en(o_pullup_en), .i_drive_val(drive_val), .i_drive_en(drive_en),
        .o_level(pin_level)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // pulses are registered, so count them mid-cycle where they are settled
    always @(negedge i_clk) begin
        n_cnt += o_count_pulse;
        n_low += o_cap_low;
        n_high += o_cap_high;
    end
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count++;
            conclude();
        end
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
        logic a, w, b, done;
        done = 1'b0;
        @(posedge i_clk);
        i_awaddr <= {idx, 2'b00};
        i_wdata <= {24'h000000, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        for (int k = 0; k < 40 && !done; k++) begin
            @(negedge i_clk);
            a = o_awready;
            w = o_wready;
            b = o_bvalid;
            r = o_bresp;
            @(posedge i_clk);
            if (a) i_awvalid <= 1'b0;
            if (w) i_wvalid <= 1'b0;
            if (b) i_bready <= 1'b0;
            done = b;
        end
        chk(32'(done), 32'h1);
    endtask
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        logic a, v, done;
        done = 1'b0;
        @(posedge i_clk);
        i_araddr <= {idx, 2'b00};
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        for (int k = 0; k < 40 && !done; k++) begin
            @(negedge i_clk);
            a = o_arready;
            v = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_clk);
            if (a) i_arvalid <= 1'b0;
            if (v) i_rready <= 1'b0;
            done = v;
        end
        chk(32'(done), 32'h1);
    endtask
    task automatic rc(input logic [15:0] idx, input logic [7:0] e);
        rd(idx, rdv, rsp);
        chk(rdv, 32'(e));
    endtask
    // pin level needs the synchroniser and detect stages before it counts
    task automatic pins(input logic [3:0] v);
        @(posedge i_clk);
        drive_val <= v;
        repeat (8) @(posedge i_clk);
    endtask

    initial begin
        {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_deep_stop} = '0;
        i_awaddr = '0;
        i_araddr = '0;
        i_wdata = '0;
        i_wstrb = 4'hF;
        drive_val = 4'h0;
        drive_en = 4'hF;
        repeat (10) @(posedge i_clk);
        i_rst_n <= 1'b1;
        for (int i = 0; i < 5; i++) rc(P_PORT + 16'(i), 8'h00);
        rd(16'h0100, rdv, rsp);
        chk(32'(rsp), SLV);
        chk(rdv, 32'h0);
        wr(16'h0100, 8'hFF, rsp);
        chk(32'(rsp), SLV);
        i_wstrb <= 4'hE;
        wr(P_ISL, 8'h55, rsp);
        rc(P_ISL, 8'h00);
        i_wstrb <= 4'hF;
        $display("test registers done");
        drive_en <= 4'h0;
        wr(P_PORT, 8'hF5, rsp);
        pins(4'h0);
        chk(32'(o_pin_oe_n), 32'h1);
        chk(32'(o_pin), 32'h4);
        chk(32'(o_pullup_en), 32'h5);
        rc(P_PORT, 8'hF5);
        rc(P_VIEW, 8'hF5);
        drive_en <= 4'hF;
        wr(P_PORT, 8'h05, rsp);
        pins(4'hA);
        rc(P_PORT, 8'h0A);
        rc(P_VIEW, 8'h05);
        chk(32'(o_pin_oe_n), 32'hF);
        wr(P_VIEW, 8'h1E, rsp);
        chk(32'(o_pin_oe_n), 32'hE);
        chk(32'(o_pin[0]), 32'h0);
        chk(32'(o_pullup_en), 32'hE);
        wr(P_PORT, 8'h00, rsp);
        $display("test port done");
        pins(4'hF);
        wr(P_ISL, 8'hC0, rsp);
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) begin
                cfg = 8'({m[1:0], 2'b01}) << (4 * s);
                fl = 8'h02 << (4 * s);
                va = 4'hF;
                va[s] = m[1];
                vi = va ^ (4'h1 << s);
                pins(vi);
                // old level config may set the flag in the write cycle itself
                repeat (2) wr(P_LVL, cfg, rsp);
                rc(P_LVL, cfg);
                n0 = n_low + n_high;
                pins(va);
                rc(P_LVL, cfg | fl);
                chk(32'(o_irq_req[s]), 32'h1);
                chk(32'(o_stop_release), 32'(m[0]));
                @(negedge i_clk);
                chk(32'(s ? o_cap_high : o_cap_low), 32'(m[0]));
                if (!m[0]) chk(32'(n_low + n_high - n0), 32'h1);
                wr(P_LVL, cfg, rsp);
                rc(P_LVL, m[0] ? (cfg | fl) : cfg);
            end
        end
        $display("test level sources done");
        pins(4'hB);
        repeat (2) wr(P_LVL, 8'h01, rsp);
        wr(P_EDGE, 8'h09, rsp);
        i_deep_stop <= 1'b1;
        repeat (3) @(posedge i_clk);
        pins(4'hA);
        rc(P_LVL, 8'h01);
        chk(32'(o_stop_release), 32'h0);
        wr(P_LVL, 8'h05, rsp);
        rc(P_LVL, 8'h07);
        chk(32'(o_stop_release), 32'h1);
        wr(P_LVL, 8'h00, rsp);
        pins(4'hE);
        rc(P_EDGE, 8'h0B);
        chk(32'(o_stop_release), 32'h1);
        wr(P_EDGE, 8'h05, rsp);
        pins(4'hA);
        rc(P_EDGE, 8'h05);
        wr(P_EDGE, 8'h0D, rsp);
        pins(4'hE);
        rc(P_EDGE, 8'h0F);
        i_deep_stop <= 1'b0;
        repeat (2) @(posedge i_clk);
        // re-enter stop with pin two high, so rises are ignored
        i_deep_stop <= 1'b1;
        repeat (3) @(posedge i_clk);
        wr(P_EDGE, 8'h0D, rsp);
        pins(4'hA);
        rc(P_EDGE, 8'h0F);
        wr(P_EDGE, 8'h0D, rsp);
        pins(4'hE);
        rc(P_EDGE, 8'h0D);
        i_deep_stop <= 1'b0;
        $display("test deep stop done");
        for (int s = 2; s < 4; s++) begin
            wr(P_ISL, 8'(s - 2), rsp);
            for (int c = 1; c < 4; c++) begin
                cfg = 8'({c[1:0], 2'b01}) << (4 * (s - 2));
                fl = 8'h02 << (4 * (s - 2));
                nev = (c & 1) + (c >> 1);
                pins(4'h3);
                wr(P_EDGE, cfg, rsp);
                n0 = n_cnt;
                l0 = n_low;
                h0 = n_high;
                pins(4'h3 | (4'h1 << s));
                rc(P_EDGE, c[1] ? (cfg | fl) : cfg);
                chk(32'(o_irq_req[s]), 32'(c[1]));
                chk(32'(o_stop_release), 32'(c[1] && s == 2));
                wr(P_EDGE, cfg, rsp);
                pins(4'h3);
                rc(P_EDGE, c[0] ? (cfg | fl) : cfg);
                chk(32'(n_cnt - n0), 32'(nev));
                chk(32'(n_low - l0), s == 2 ? 32'(nev) : 32'h0);
                chk(32'(n_high - h0), s == 3 ? 32'(nev) : 32'h0);
            end
        end
        $display("test edge sources done");
        conclude();
    end
endmodule // tb_quad_io_port
